// ---- design/nafmt_defs.vh ----
// constants for the number to ascii string formatter
// assumes nothing; included by bare name from design files
`ifndef NAFMT_DEFS_VH
`define NAFMT_DEFS_VH

// operand kinds on cmd_kind
`define NAFMT_KIND_INT16    2'h0
`define NAFMT_KIND_INT32    2'h1
`define NAFMT_KIND_REAL     2'h2

// format_byte field positions
`define NAFMT_FMT_LEN_HI    7
`define NAFMT_FMT_LEN_LO    4
`define NAFMT_FMT_SEP_BIT   3
`define NAFMT_FMT_NNN_HI    2
`define NAFMT_FMT_NNN_LO    0

// limits and fixed string lengths
`define NAFMT_NNN_MAX       3'h5
`define NAFMT_LEN_INT16     4'h8
`define NAFMT_LEN_INT32     4'hc
`define NAFMT_LEN_REAL_MIN  4'h3
`define NAFMT_BUF_DEPTH     15

// ascii characters
`define NAFMT_CH_SPACE      8'h20
`define NAFMT_CH_MINUS      8'h2d
`define NAFMT_CH_COMMA      8'h2c
`define NAFMT_CH_PERIOD     8'h2e
`define NAFMT_CH_ZERO       8'h30

// single precision real layout
`define NAFMT_REAL_BIAS     150
`define NAFMT_REAL_SHL_MAX  23
`define NAFMT_REAL_EXP_MAX  8'hff

// powers of ten for fraction scaling
`define NAFMT_P10_0         17'h00001
`define NAFMT_P10_1         17'h0000a
`define NAFMT_P10_2         17'h00064
`define NAFMT_P10_3         17'h003e8
`define NAFMT_P10_4         17'h02710
`define NAFMT_P10_5         17'h186a0

// reset value of the enable-out flag
`define NAFMT_ENO_RESET     1'h0

`endif

// ---- design/nafmt_div10.v ----
// divide by ten: one decimal digit per use
// assumes a registered caller on the same clock
`timescale 1ns/100ps
`default_nettype none

module nafmt_div10 (
	// dividend
	input  wire [63:0] val,
	// results
	output wire [63:0] quo,
	output wire [3:0]  rem
);

	wire [63:0] full_rem;

	// constant divisor keeps this a plain reciprocal network
	assign quo      = val / 64'h000000000000000a;
	assign full_rem = val % 64'h000000000000000a;
	assign rem      = full_rem[3:0];

endmodule // nafmt_div10

`default_nettype wire

// ---- design/nafmt_core.v ----
// number to ascii string formatter: int16, int32 or real to a length-prefixed string
// assumes the sequencer holds command inputs valid with cmd_start, all on sys_clk
//
// What this block does
// - int16 gives 8 chars, 9 bytes
// - int32 gives 12 chars, 13 bytes
// - length byte first, characters follow
// - fraction count above five is illegal
// - zero fraction digits: no separator
// - int16 bad count gives 8 spaces
// - int32 bad count gives 12 spaces
// - separator comma if bit set, else period
// - faults and illegal format clear enable-out
// - minus only for negative values
// - suppress leading zeros, keep units digit
// - right justify, pad with spaces
// - real length from format, 3 to 15
// - real length below three is illegal
// - real: spaces if count bad or overflow
// - real fraction rounded to digit count
// - real carries about seven significant digits
`timescale 1ns/100ps
`default_nettype none
`include "nafmt_defs.vh"

module nafmt_core (
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst_b,
	// command from the sequencer
	input  wire        cmd_start,
	input  wire [1:0]  cmd_kind,
	input  wire [31:0] cmd_operand,
	input  wire [7:0]  cmd_format_byte,
	input  wire [15:0] cmd_dest_addr,
	input  wire        cmd_addr_fault,
	input  wire        cmd_range_fault,
	// data memory write port
	output reg         mem_we,
	output reg  [15:0] mem_addr,
	output reg  [7:0]  mem_wdata,
	// status
	output reg         busy,
	output reg         done,
	output reg         enable_out_flag
);

	localparam [1:0] ST_IDLE  = 2'h0;
	localparam [1:0] ST_SCALE = 2'h1;
	localparam [1:0] ST_DIGIT = 2'h2;
	localparam [1:0] ST_WRITE = 2'h3;

	reg  [1:0]  state;
	reg  [1:0]  kind;
	reg  [2:0]  nnn;
	reg         sep_comma;
	reg  [3:0]  len;
	reg  [31:0] opnd;
	reg  [15:0] dest;
	reg  [63:0] mag;
	reg         neg;
	reg  [3:0]  pos;
	reg  [4:0]  cnt;
	reg         sep_done;
	reg         eno_pend;
	reg  [4:0]  wr_idx;

	// format fields of the incoming command
	wire [2:0]  in_nnn  = cmd_format_byte[`NAFMT_FMT_NNN_HI:`NAFMT_FMT_NNN_LO];
	wire [3:0]  in_ssss = cmd_format_byte[`NAFMT_FMT_LEN_HI:`NAFMT_FMT_LEN_LO];
	wire        in_sep  = cmd_format_byte[`NAFMT_FMT_SEP_BIT];
	wire        in_real = (cmd_kind == `NAFMT_KIND_REAL);
	wire        start_take = cmd_start && (state == ST_IDLE);

	// the upper nibble of an integer format is left unchecked
	wire        nnn_bad = (in_nnn > `NAFMT_NNN_MAX);

	// commands that write nothing at all
	wire        len_bad = in_real && (in_ssss < `NAFMT_LEN_REAL_MIN);
	wire        inf_nan = in_real && (cmd_operand[30:23] == `NAFMT_REAL_EXP_MAX);
	wire        kind_bad = (cmd_kind == 2'h3);
	wire        abort = cmd_addr_fault || cmd_range_fault || kind_bad || inf_nan || len_bad;

	// fixed or programmed string length
	reg  [3:0]  len_sel;
	always @* begin
		if (cmd_kind == `NAFMT_KIND_INT16) begin
			len_sel = `NAFMT_LEN_INT16;
		end else if (cmd_kind == `NAFMT_KIND_INT32) begin
			len_sel = `NAFMT_LEN_INT32;
		end else begin
			len_sel = in_ssss;
		end
	end

	// integer magnitude and sign, taken straight from the operand
	wire [15:0] i16     = cmd_operand[15:0];
	wire [15:0] i16_abs = i16[15] ? (~i16 + 16'h0001) : i16;
	wire [31:0] i32_abs = cmd_operand[31] ? (~cmd_operand + 32'h00000001) : cmd_operand;
	wire        int_neg = (cmd_kind == `NAFMT_KIND_INT16) ? i16[15] : cmd_operand[31];
	wire [63:0] int_mag = (cmd_kind == `NAFMT_KIND_INT16) ? {48'h0, i16_abs} : {32'h0, i32_abs};

	// power of ten for the latched fraction count
	reg  [16:0] p10;
	always @* begin
		case (nnn)
			3'h0: p10 = `NAFMT_P10_0;
			3'h1: p10 = `NAFMT_P10_1;
			3'h2: p10 = `NAFMT_P10_2;
			3'h3: p10 = `NAFMT_P10_3;
			3'h4: p10 = `NAFMT_P10_4;
			default: p10 = `NAFMT_P10_5;
		endcase
	end

	// real scaling: mantissa times ten to nnn, then binary exponent with half-up rounding
	// only the 24-bit mantissa is kept, so digits past about seven are noise
	reg  [40:0] r_prod;
	reg  [63:0] r_ext;
	reg  [63:0] r_mag;
	reg         r_big;
	integer     sh;
	integer     rsh;
	always @* begin
		r_prod = {17'h0, 1'b1, opnd[22:0]} * {24'h0, p10};
		r_ext  = {23'h0, r_prod};
		r_mag  = 64'h0;
		r_big  = 1'b0;
		sh     = opnd[30:23];
		sh     = sh - `NAFMT_REAL_BIAS;
		rsh    = 0 - sh;
		if (opnd[30:23] == 8'h00) begin
			r_mag = 64'h0; // denormals flush to zero
		end else if (sh >= 0) begin
			if (sh > `NAFMT_REAL_SHL_MAX) begin
				r_big = 1'b1;
			end else begin
				r_mag = r_ext << sh;
			end
		end else begin
			r_mag = (r_ext + (64'h1 << (rsh - 1))) >> rsh;
		end
	end

	// one decimal digit per digit step
	wire [63:0] quo;
	wire [3:0]  rem;
	nafmt_div10 nafmt_div10_i (
		.val (mag),
		.quo (quo),
		.rem (rem)
	);

	// what the digit step writes next, from the right end leftward
	wire        dig_pending = (cnt <= {2'h0, nnn}) || (mag != 64'h0);
	wire        sep_pending = (nnn != 3'h0) && (cnt == {2'h0, nnn}) && !sep_done;
	wire        more        = sep_pending || dig_pending || neg;
	wire        in_digit    = (state == ST_DIGIT);
	wire        ovf         = in_digit && more && (pos == 4'h0);
	wire        buf_we      = in_digit && more && (pos != 4'h0);
	wire [7:0]  sep_ch      = sep_comma ? `NAFMT_CH_COMMA : `NAFMT_CH_PERIOD;
	reg  [7:0]  buf_char;
	always @* begin
		if (sep_pending) begin
			buf_char = sep_ch;
		end else if (dig_pending) begin
			buf_char = `NAFMT_CH_ZERO + {4'h0, rem};
		end else begin
			buf_char = `NAFMT_CH_MINUS;
		end
	end

	// buffer is wiped to spaces on a new command or when the string does not fit
	wire        buf_clear = start_take || ovf || ((state == ST_SCALE) && r_big);

	// character buffer, entry i holds string position i+1
	wire [8*`NAFMT_BUF_DEPTH-1:0] buf_flat;
	genvar gi;
	generate
		for (gi = 0; gi < `NAFMT_BUF_DEPTH; gi = gi + 1) begin : g_entry
			localparam [3:0] ENTRY_POS = gi + 1;
			reg [7:0] ch;
			always @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					ch <= `NAFMT_CH_SPACE;
				end else if (buf_clear) begin
					ch <= `NAFMT_CH_SPACE;
				end else if (buf_we && (pos == ENTRY_POS)) begin
					ch <= buf_char;
				end
			end
			assign buf_flat[8*gi+7:8*gi] = ch;
		end
	endgenerate

	// read side for the memory write sequence
	wire [3:0]  rd_sel  = wr_idx[3:0] - 4'h1;
	wire [7:0]  rd_char = buf_flat[{rd_sel, 3'b000} +: 8];

	// main sequencer
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state           <= ST_IDLE;
			kind            <= `NAFMT_KIND_INT16;
			nnn             <= 3'h0;
			sep_comma       <= 1'b0;
			len             <= 4'h0;
			opnd            <= 32'h0;
			dest            <= 16'h0;
			mag             <= 64'h0;
			neg             <= 1'b0;
			pos             <= 4'h0;
			cnt             <= 5'h0;
			sep_done        <= 1'b0;
			eno_pend        <= 1'b0;
			wr_idx          <= 5'h0;
			mem_we          <= 1'b0;
			mem_addr        <= 16'h0;
			mem_wdata       <= 8'h0;
			busy            <= 1'b0;
			done            <= 1'b0;
			enable_out_flag <= `NAFMT_ENO_RESET;
		end else begin
			mem_we <= 1'b0;
			done   <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (cmd_start) begin
						kind      <= cmd_kind;
						nnn       <= in_nnn;
						sep_comma <= in_sep;
						len       <= len_sel;
						pos       <= len_sel;
						opnd      <= cmd_operand;
						dest      <= cmd_dest_addr;
						mag       <= int_mag;
						neg       <= int_neg;
						cnt       <= 5'h0;
						sep_done  <= 1'b0;
						wr_idx    <= 5'h0;
						if (abort) begin
							// nothing is written, the flag drops at once
							done            <= 1'b1;
							enable_out_flag <= 1'b0;
						end else if (nnn_bad) begin
							// spaces already loaded, go straight to the write-out
							busy     <= 1'b1;
							eno_pend <= 1'b0;
							state    <= ST_WRITE;
						end else begin
							busy     <= 1'b1;
							eno_pend <= 1'b1;
							state    <= in_real ? ST_SCALE : ST_DIGIT;
						end
					end
				end
				ST_SCALE: begin
					if (r_big) begin
						eno_pend <= 1'b0;
						state    <= ST_WRITE;
					end else begin
						mag   <= r_mag;
						neg   <= opnd[31] && (r_mag != 64'h0); // rounded-away value shows no sign
						state <= ST_DIGIT;
					end
				end
				ST_DIGIT: begin
					if (ovf) begin
						// only a real can outgrow its string; integers always fit
						eno_pend <= 1'b0;
						state    <= ST_WRITE;
					end else if (buf_we) begin
						pos <= pos - 4'h1;
						if (sep_pending) begin
							sep_done <= 1'b1;
						end else if (dig_pending) begin
							mag <= quo;
							cnt <= cnt + 5'h01;
						end else begin
							neg <= 1'b0;
						end
					end else begin
						state <= ST_WRITE;
					end
				end
				default: begin
					if (wr_idx <= {1'b0, len}) begin
						mem_we   <= 1'b1;
						mem_addr <= dest + {11'h0, wr_idx};
						// first byte is the length, then characters in order
						if (wr_idx == 5'h00) begin
							mem_wdata <= {4'h0, len};
						end else begin
							mem_wdata <= rd_char;
						end
						wr_idx <= wr_idx + 5'h01;
					end else begin
						busy            <= 1'b0;
						done            <= 1'b1;
						enable_out_flag <= eno_pend;
						state           <= ST_IDLE;
					end
				end
			endcase
		end
	end

endmodule // nafmt_core

`default_nettype wire

// ---- bench/nafmt_mem_model.sv ----
// data memory model: byte sink for the write port
// assumes one write per clock, no wait states
`timescale 1ns/100ps
`default_nettype none
module nafmt_mem_model (
	// write port
	input wire logic        sys_clk,
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata
);
	logic [7:0] mem [0:65535];
	int         nw = 0;
	// never stalls, so bytes may stream back to back
	always @(posedge sys_clk) begin
		if (mem_we) begin
			mem[mem_addr] <= mem_wdata;
			nw <= nw + 1;
		end
	end
endmodule // nafmt_mem_model
`default_nettype wire

// ---- bench/nafmt_core_props.sv ----
// checker: ties written bytes to the accepted command
// assumes a bind onto nafmt_core, one clock, async low reset
`timescale 1ns/100ps
`default_nettype none
module nafmt_core_props (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// command
	input wire logic        cmd_start,
	input wire logic [1:0]  cmd_kind,
	input wire logic [7:0]  cmd_format_byte,
	input wire logic [15:0] cmd_dest_addr,
	input wire logic        cmd_addr_fault,
	input wire logic        cmd_range_fault,
	// memory and status
	input wire logic        mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0]  mem_wdata,
	input wire logic        busy,
	input wire logic        done,
	input wire logic        enable_out_flag
);
	logic [1:0]  k;
	logic [3:0]  rl;
	logic        nbad;
	logic [4:0]  wi;
	logic [15:0] da;
	wire         take = cmd_start && !busy;
	wire         ok = !cmd_addr_fault && !cmd_range_fault;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// latch the taken command; count its bytes
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{k, rl, nbad, wi, da} <= '0;
		end else if (take) begin
			{k, rl, nbad, wi, da} <= {cmd_kind, cmd_format_byte[7:4], cmd_format_byte[2:0] > 3'h5, 5'h00,
				cmd_dest_addr};
		end else if (mem_we) begin
			wi <= wi + 5'h01;
		end
	end
	property p_abort; take && !ok |=> done && !enable_out_flag && !mem_we; endproperty
	a_abort: assert property (p_abort) else $error("fault not aborted");
	property p_short; take && ok && cmd_kind == 2'h2 && cmd_format_byte[7:4] < 4'h3 |=> done && !enable_out_flag;
	endproperty
	a_short: assert property (p_short) else $error("short length taken");
	property p_len; mem_we && wi == 5'h00 |-> mem_wdata == (k == 2'h0 ? 8'h08 : k == 2'h1 ? 8'h0c : {4'h0, rl});
	endproperty
	a_len: assert property (p_len) else $error("bad length byte");
	property p_addr; mem_we |-> mem_addr == da + {11'h000, wi}; endproperty
	a_addr: assert property (p_addr) else $error("bad byte address");
	property p_n16; done && enable_out_flag && k == 2'h0 |-> wi == 5'h09; endproperty
	a_n16: assert property (p_n16) else $error("int16 byte count");
	property p_n32; done && enable_out_flag && k == 2'h1 |-> wi == 5'h0d; endproperty
	a_n32: assert property (p_n32) else $error("int32 byte count");
	property p_nnn; done && nbad |-> !enable_out_flag; endproperty
	a_nnn: assert property (p_nnn) else $error("bad count not flagged");
	property p_space; mem_we && wi != 5'h00 && nbad |-> mem_wdata == 8'h20; endproperty
	a_space: assert property (p_space) else $error("fill not space");
	cover property (take && !ok);
	cover property (done && enable_out_flag);
	cover property (mem_we && nbad);
endmodule // nafmt_core_props
`default_nettype wire

// ---- bench/nafmt_core_bench.sv ----
// bench: sequencer task issues commands, memory model holds strings
// assumes nafmt_core, nafmt_mem_model, nafmt_core_props compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module nafmt_core_bench;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cmd_start = 1'b0;
	logic [1:0]  cmd_kind = 2'h0;
	logic [31:0] cmd_operand = 32'h00000000;
	logic [7:0]  cmd_format_byte = 8'h00;
	logic [15:0] cmd_dest_addr = 16'h0000;
	logic        cmd_addr_fault = 1'b0;
	logic        cmd_range_fault = 1'b0;
	wire         mem_we, busy, done, enable_out_flag;
	wire  [15:0] mem_addr;
	wire  [7:0]  mem_wdata;
	logic [15:0] dst = 16'hfffa;
	int          n_mismatch = 0;
	int          tests_run = 0;
	int          tn = 0;
	nafmt_core nafmt_core_i (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_start(cmd_start), .cmd_kind(cmd_kind),
		.cmd_operand(cmd_operand), .cmd_format_byte(cmd_format_byte), .cmd_dest_addr(cmd_dest_addr),
		.cmd_addr_fault(cmd_addr_fault), .cmd_range_fault(cmd_range_fault), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .busy(busy), .done(done), .enable_out_flag(enable_out_flag));
	nafmt_mem_model nafmt_mem_model_i (.sys_clk(sys_clk), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
	// 250 MHz
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one command; dup retries start while busy, which must be ignored
	task automatic run(input [1:0] k, input [31:0] op, input [7:0] f, input [1:0] flt, input bit dup,
		input logic e, input string s);
		int i;
		int j;
		int n0;
		logic [15:0] d;
		d = dst;
		dst = dst + 16'h0020;
		n0 = nafmt_mem_model_i.nw;
		// launch the command on a rising edge, as the sequencer does
		@(posedge sys_clk);
		{cmd_kind, cmd_operand, cmd_format_byte, cmd_dest_addr} <= {k, op, f, d};
		{cmd_addr_fault, cmd_range_fault} <= flt;
		cmd_start <= 1'b1;
		for (i = 0; i < 60; i++) begin
			@(posedge sys_clk);
			cmd_start <= dup && i == 1;
			cmd_addr_fault <= dup && i == 1;
			#1;
			if (done === 1'b1)
				break;
		end
		`CHK(i < 60, 1'b1)
		`CHK(enable_out_flag, e)
		`CHK(busy, 1'b0)
		if (s.len() == 0)
			`CHK(nafmt_mem_model_i.nw, n0)
		else begin
			`CHK(nafmt_mem_model_i.mem[d], 8'(s.len()))
			for (j = 1; j <= s.len(); j++)
				`CHK(nafmt_mem_model_i.mem[d + 16'(j)], 8'(s[j-1]))
		end
		tn++;
		$display("test %0d done", tn);
	endtask
	// hang guard: tests need well under 1000 cycles
	initial begin
		#(5000 * 4);
		n_mismatch++;
		give_verdict;
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rst_b <= 1'b1;
		#1;
		run(2'h0, 32'h0000000c, 8'h03, 2'h0, 0, 1, "   0.012");
		run(2'h0, 32'h0000ff85, 8'h0b, 2'h0, 0, 1, "  -0,123");
		run(2'h0, 32'h00008000, 8'h00, 2'h0, 0, 1, "  -32768");
		run(2'h0, 32'h000004d2, 8'h06, 2'h0, 0, 0, "        ");
		run(2'h1, 32'hffed2979, 8'h04, 2'h0, 0, 1, "   -123.4567");
		run(2'h1, 32'h0000000c, 8'h05, 2'h0, 1, 1, "     0.00012");
		run(2'h1, 32'h00000007, 8'h0f, 2'h0, 0, 0, "            ");
		run(2'h2, 32'h449a5000, 8'h61, 2'h0, 0, 1, "1234.5");
		run(2'h2, 32'h449a5000, 8'hf1, 2'h0, 0, 1, "         1234.5");
		run(2'h2, 32'hc0700000, 8'h61, 2'h0, 0, 1, "  -3.8");
		run(2'h2, 32'h40000000, 8'h38, 2'h0, 0, 1, "  2");
		run(2'h2, 32'h449a5000, 8'h51, 2'h0, 0, 0, "     ");
		run(2'h2, 32'h449a5000, 8'h21, 2'h0, 0, 0, "");
		run(2'h0, 32'h0000000c, 8'h03, 2'h2, 0, 0, "");
		run(2'h1, 32'h0000000c, 8'h04, 2'h1, 0, 0, "");
		run(2'h3, 32'h0000000c, 8'h03, 2'h0, 0, 0, "");
		give_verdict;
	end
endmodule // nafmt_core_bench
bind nafmt_core nafmt_core_props nafmt_core_props_i (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_start(cmd_start),
	.cmd_kind(cmd_kind), .cmd_format_byte(cmd_format_byte), .cmd_dest_addr(cmd_dest_addr),
	.cmd_addr_fault(cmd_addr_fault), .cmd_range_fault(cmd_range_fault), .mem_we(mem_we), .mem_addr(mem_addr),
	.mem_wdata(mem_wdata), .busy(busy), .done(done), .enable_out_flag(enable_out_flag));
`default_nettype wire
